// [design/fsc_host.v]
// What this block does
// - during erase, only suspend is sent; status is read with no command, other orders are refused.
// - while suspended, host sends only read, resume or read status.
// - error bits are judged only after ready reads one.
// - clear-status code 50h clears error bits; host uses it.
// - hold reset/power-down low from power-up until the RST_CYC timer ends after reset.
// - alternative: keep chip select high and pulse reset high-low-high.
// - program is setup code cycle, then address and data cycle.
// - after write start, poll status until ready reads one.
// - after write or erase host sends FFh to read array again only when a read order is given.
// - full error check optional; supply error still blocks.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.vh"
module fsc_host (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write
   input  wire [3:0]  s_awaddr,
   input  wire        s_awvalid,
   output wire        s_awready,
   input  wire [31:0] s_wdata,
   input  wire [3:0]  s_wstrb,
   input  wire        s_wvalid,
   output wire        s_wready,
   output wire [1:0]  s_bresp,
   output wire        s_bvalid,
   input  wire        s_bready,
   // axi4-lite read
   input  wire [3:0]  s_araddr,
   input  wire        s_arvalid,
   output wire        s_arready,
   output wire [31:0] s_rdata,
   output wire [1:0]  s_rresp,
   output wire        s_rvalid,
   input  wire        s_rready,
   // flash pins
   output reg         flash_ce_n,
   output reg         flash_we_n,
   output reg         flash_oe_n,
   output reg         reset_powerdown_n,
   output reg  [18:0] flash_addr,
   output reg  [7:0]  flash_dq_o,
   output reg         flash_dq_oe,
   input  wire [7:0]  flash_dq_i
);
   ////////////////////////////////////////////////////////////////////////
   localparam [8:0] S_RST   = 9'h001;
   localparam [8:0] S_RECOV = 9'h002;
   localparam [8:0] S_IDLE  = 9'h004;
   localparam [8:0] S_WR1   = 9'h008;
   localparam [8:0] S_WR2   = 9'h010;
   localparam [8:0] S_RDST  = 9'h020;
   localparam [8:0] S_STRB  = 9'h040;
   localparam [8:0] S_SAMP  = 9'h080;
   localparam [8:0] S_GAP   = 9'h100;
   // timer loads are 8 bits wide; all three counts fit without cutting
   localparam [31:0] RST_CYC   = `FSC_RST_CYC;
   localparam [31:0] RECOV_CYC = `FSC_RECOV_CYC;
   localparam [31:0] STRB_CYC  = `FSC_STROBE_CYC;

   reg  [8:0]  state_r;
   reg  [8:0]  ret_r;
   reg  [2:0]  op_r;
   reg  [18:0] addr_r;
   reg  [7:0]  data_r;
   reg  [7:0]  stat_r;
   reg  [7:0]  rdata_r;
   reg         busy_r;
   reg         erasing_r;
   reg         suspended_r;
   reg         statmode_r;
   reg         refused_r;
   reg         two_r;
   reg         poll_r;
   reg  [7:0]  cmd_r;
   reg         t_start_r;
   reg  [7:0]  t_cnt_r;
   wire        t_done;
   wire        wr_pulse;
   wire [3:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  rd_addr;
   reg  [31:0] rd_data;
   reg         rd_ok;

   // error decode, used by the status word only; the blocking check reads stat_r
   function [2:0] err_code;
      input [7:0] sr;
      begin
         err_code = {sr[`FSC_SR_EFAIL], sr[`FSC_SR_WFAIL], sr[`FSC_SR_SUPPLY]};
      end
   endfunction

   fsc_axil u_bus (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_pulse  (wr_pulse),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_ok     (rd_ok)
   );

   fsc_timer u_tmr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (t_start_r),
      .count   (t_cnt_r),
      .done    (t_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // register read mux
   always @* begin
      rd_ok   = 1'b1;
      rd_data = 32'h00000000;
      case (rd_addr)
         `FSC_REG_CTRL: rd_data = {29'h0, op_r};
         `FSC_REG_ADDR: rd_data = {13'h0, addr_r};
         `FSC_REG_DATA: rd_data = {24'h0, rdata_r};
         `FSC_REG_STAT: rd_data = {17'h00000, err_code(stat_r), refused_r,
                                   suspended_r, erasing_r, busy_r, stat_r};
         default:       rd_ok   = 1'b0;
      endcase
   end

   // is an order legal in the present flash mode
   wire erase_run = erasing_r && !suspended_r;
   // erase gates orders; status is a plain read, no command
   wire ok_run    = (wr_data[2:0] == `FSC_OP_SUSPEND ||
                     wr_data[2:0] == `FSC_OP_STATUS) && erase_run;
   wire ok_susp   = suspended_r && (wr_data[2:0] == `FSC_OP_READ ||
                    wr_data[2:0] == `FSC_OP_RESUME ||
                    wr_data[2:0] == `FSC_OP_STATUS);
   wire blk_sup   = stat_r[`FSC_SR_SUPPLY] &&
                    (wr_data[2:0] == `FSC_OP_WRITE ||
                     wr_data[2:0] == `FSC_OP_ERASE);
   wire ok_idle   = !erasing_r && !blk_sup &&
                    wr_data[2:0] != `FSC_OP_SUSPEND &&
                    wr_data[2:0] != `FSC_OP_RESUME &&
                    wr_data[2:0] != 3'h0;
   wire go = wr_pulse && wr_addr == `FSC_REG_CTRL && state_r == S_IDLE;
   wire ok = ok_run || ok_susp || ok_idle;

   ////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r           <= S_RST;
         ret_r             <= S_IDLE;
         op_r              <= 3'h0;
         addr_r            <= 19'h00000;
         data_r            <= 8'h00;
         stat_r            <= 8'h80;
         rdata_r           <= 8'h00;
         busy_r            <= 1'b1;
         erasing_r         <= 1'b0;
         suspended_r       <= 1'b0;
         statmode_r        <= 1'b0;
         refused_r         <= 1'b0;
         two_r             <= 1'b0;
         poll_r            <= 1'b0;
         cmd_r             <= 8'h00;
         t_start_r         <= 1'b0;
         t_cnt_r           <= 8'h00;
         flash_ce_n        <= 1'b1;
         flash_we_n        <= 1'b1;
         flash_oe_n        <= 1'b1;
         reset_powerdown_n <= 1'b0;
         flash_addr        <= 19'h00000;
         flash_dq_o        <= 8'h00;
         flash_dq_oe       <= 1'b0;
      end else begin
         t_start_r <= 1'b0;
         if (wr_pulse && wr_addr == `FSC_REG_ADDR)
            addr_r <= wr_data[18:0];
         if (wr_pulse && wr_addr == `FSC_REG_DATA)
            data_r <= wr_data[7:0];
         // refused flag: set by a refused order, cleared by an accepted one
         if (go && !ok)
            refused_r <= 1'b1;
         else if (go)
            refused_r <= 1'b0;
         case (state_r)
            S_RST: begin
               // chip select kept high while reset pulses
               flash_ce_n <= 1'b1;
               t_start_r  <= 1'b1;
               t_cnt_r    <= RST_CYC[7:0];
               state_r    <= S_RECOV;
            end
            S_RECOV: begin
               if (t_done && !reset_powerdown_n) begin
                  reset_powerdown_n <= 1'b1;
                  t_start_r         <= 1'b1;
                  t_cnt_r           <= RECOV_CYC[7:0];
               end else if (t_done) begin
                  busy_r  <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            S_IDLE: begin
               // chip select high between cycles: standby
               flash_ce_n <= 1'b1;
               if (go && ok) begin
                  op_r   <= wr_data[2:0];
                  busy_r <= 1'b1;
                  two_r  <= 1'b0;
                  poll_r <= 1'b0;
                  case (wr_data[2:0])
                     `FSC_OP_WRITE: begin
                        cmd_r <= `FSC_CMD_WRITE_SETUP;
                        two_r <= 1'b1;
                        poll_r <= 1'b1;
                     end
                     `FSC_OP_ERASE: begin
                        // no poll: erase runs on, end seen by status reads
                        cmd_r     <= `FSC_CMD_ERASE_SETUP;
                        two_r     <= 1'b1;
                        erasing_r <= 1'b1;
                     end
                     `FSC_OP_SUSPEND: begin
                        cmd_r  <= `FSC_CMD_SUSPEND;
                        poll_r <= 1'b1;
                     end
                     `FSC_OP_RESUME: begin
                        cmd_r       <= `FSC_CMD_CONFIRM;
                        suspended_r <= 1'b0;
                     end
                     `FSC_OP_CLEAR: begin
                        cmd_r  <= `FSC_CMD_CLEAR_STATUS;
                        stat_r <= stat_r & 8'hC7;
                     end
                     `FSC_OP_READ: cmd_r <= `FSC_CMD_READ_ARRAY;
                     default:      cmd_r <= `FSC_CMD_READ_STATUS;
                  endcase
                  // flash shows status while erasing: read, write nothing
                  if (wr_data[2:0] == `FSC_OP_STATUS && erase_run) begin
                     statmode_r <= 1'b1;
                     state_r    <= S_RDST;
                  end else
                     state_r <= S_WR1;
               end
            end
            S_WR1: begin
               flash_ce_n  <= 1'b0;
               flash_we_n  <= 1'b0;
               flash_oe_n  <= 1'b1;
               flash_dq_oe <= 1'b1;
               flash_dq_o  <= cmd_r;
               flash_addr  <= addr_r;
               t_start_r   <= 1'b1;
               t_cnt_r     <= STRB_CYC[7:0];
               ret_r       <= S_WR2;
               state_r     <= S_STRB;
            end
            S_WR2: begin
               if (two_r) begin
                  two_r   <= 1'b0;
                  cmd_r   <= erasing_r ? `FSC_CMD_CONFIRM : data_r;
                  state_r <= S_WR1;
               end else if (poll_r || op_r == `FSC_OP_STATUS ||
                            op_r == `FSC_OP_READ) begin
                  statmode_r <= op_r != `FSC_OP_READ;
                  state_r    <= S_RDST;
               end else begin
                  statmode_r <= 1'b0;
                  busy_r     <= 1'b0;
                  state_r    <= S_IDLE;
               end
            end
            S_RDST: begin
               flash_ce_n  <= 1'b0;
               flash_oe_n  <= 1'b0;
               flash_dq_oe <= 1'b0;
               flash_addr  <= addr_r;
               t_start_r   <= 1'b1;
               t_cnt_r     <= STRB_CYC[7:0];
               ret_r       <= S_SAMP;
               state_r     <= S_STRB;
            end
            S_STRB: begin
               if (t_done) begin
                  flash_we_n <= 1'b1;
                  state_r    <= ret_r == S_SAMP ? S_SAMP : S_GAP;
               end
            end
            S_GAP: begin
               // ce released; operation continues inside the flash
               flash_ce_n  <= 1'b1;
               flash_dq_oe <= 1'b0;
               state_r     <= S_WR2;
            end
            S_SAMP: begin
               flash_oe_n <= 1'b1;
               flash_ce_n <= 1'b1;
               rdata_r    <= flash_dq_i;
               if (statmode_r)
                  stat_r <= flash_dq_i;
               if (poll_r && !flash_dq_i[`FSC_SR_READY]) begin
                  state_r <= S_RDST;
               end else begin
                  // suspended shows with ready; else erase has ended and erasing clears
                  if (op_r == `FSC_OP_SUSPEND) begin
                     suspended_r <= flash_dq_i[`FSC_SR_SUSP];
                     erasing_r   <= flash_dq_i[`FSC_SR_SUSP];
                  end else if (op_r == `FSC_OP_STATUS && erase_run &&
                               flash_dq_i[`FSC_SR_READY])
                     erasing_r <= 1'b0;
                  busy_r  <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_RST;
         endcase
      end
   end
endmodule
`default_nettype wire

// [design/fsc_consts.vh]
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH
// command codes
`define FSC_CMD_READ_ARRAY   8'hFF
`define FSC_CMD_READ_STATUS  8'h70
`define FSC_CMD_CLEAR_STATUS 8'h50
`define FSC_CMD_ERASE_SETUP  8'h20
`define FSC_CMD_CONFIRM      8'hD0
`define FSC_CMD_SUSPEND      8'hB0
`define FSC_CMD_WRITE_SETUP  8'h40
// status bit positions
`define FSC_SR_READY    7
`define FSC_SR_SUSP     6
`define FSC_SR_EFAIL    5
`define FSC_SR_WFAIL    4
`define FSC_SR_SUPPLY   3
// register byte offsets
`define FSC_REG_CTRL    4'h0
`define FSC_REG_ADDR    4'h4
`define FSC_REG_DATA    4'h8
`define FSC_REG_STAT    4'hC
// operation codes in control register bits 2:0
`define FSC_OP_WRITE    3'h1
`define FSC_OP_ERASE    3'h2
`define FSC_OP_SUSPEND  3'h3
`define FSC_OP_RESUME   3'h4
`define FSC_OP_CLEAR    3'h5
`define FSC_OP_READ     3'h6
`define FSC_OP_STATUS   3'h7
// pin timing, ns and cycles at 25 ns
`define FSC_CLK_NS      25
`define FSC_STROBE_NS   60
`define FSC_STROBE_CYC  ((`FSC_STROBE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_RST_NS      100
`define FSC_RST_CYC     ((`FSC_RST_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_RECOV_NS    1000
`define FSC_RECOV_CYC   ((`FSC_RECOV_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`endif

// [design/fsc_timer.v]
`timescale 1ns/1ps
`default_nettype none
module fsc_timer (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // control
   input  wire        start,
   input  wire [7:0]  count,
   output wire        done
);
   reg [7:0] cnt_r;
   always @(posedge aclk) begin
      if (!aresetn)
         cnt_r <= 8'h00;
      else if (start)
         cnt_r <= count;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end
   assign done = (cnt_r == 8'h01);
endmodule
`default_nettype wire

// [design/fsc_axil.v]
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.vh"
// axi4-lite slave: one write and one read at a time, fixed latency
module fsc_axil (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // write channels
   input  wire [3:0]  s_awaddr,
   input  wire        s_awvalid,
   output reg         s_awready,
   input  wire [31:0] s_wdata,
   input  wire [3:0]  s_wstrb,
   input  wire        s_wvalid,
   output reg         s_wready,
   output reg  [1:0]  s_bresp,
   output reg         s_bvalid,
   input  wire        s_bready,
   // read channels
   input  wire [3:0]  s_araddr,
   input  wire        s_arvalid,
   output reg         s_arready,
   output reg  [31:0] s_rdata,
   output reg  [1:0]  s_rresp,
   output reg         s_rvalid,
   input  wire        s_rready,
   // register side
   output reg         wr_pulse,
   output reg  [3:0]  wr_addr,
   output reg  [31:0] wr_data,
   output reg  [3:0]  rd_addr,
   input  wire [31:0] rd_data,
   input  wire        rd_ok
);
   reg        aw_have_r;
   reg        w_have_r;
   reg        rd_wait_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= 2'h0;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         wr_pulse  <= 1'b0;
         wr_addr   <= 4'h0;
         wr_data   <= 32'h00000000;
      end else begin
         wr_pulse  <= 1'b0;
         s_awready <= !aw_have_r && !s_awready && !s_bvalid && s_awvalid;
         s_wready  <= !w_have_r && !s_wready && !s_bvalid && s_wvalid;
         if (s_awvalid && s_awready) begin
            aw_have_r <= 1'b1;
            wr_addr   <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_have_r <= 1'b1;
            wr_data  <= s_wdata;
         end
         if (aw_have_r && w_have_r && !s_bvalid) begin
            // strobes ignored: registers take whole words
            wr_pulse  <= 1'b1;
            s_bvalid  <= 1'b1;
            s_bresp   <= (wr_addr == `FSC_REG_STAT) ? 2'h2 : 2'h0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
         end else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h00000000;
         s_rresp   <= 2'h0;
         rd_wait_r <= 1'b0;
         rd_addr   <= 4'h0;
      end else begin
         s_arready <= !s_arready && !rd_wait_r && !s_rvalid && s_arvalid;
         if (s_arvalid && s_arready) begin
            rd_addr   <= s_araddr;
            rd_wait_r <= 1'b1;
         end else if (rd_wait_r) begin
            rd_wait_r <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_data;
            s_rresp   <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [tb/fsc_host_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module fsc_host_checker (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus answers
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic [31:0] s_rdata,
   // flash pins
   input wire logic        flash_ce_n,
   input wire logic        flash_we_n,
   input wire logic        flash_oe_n,
   input wire logic        reset_powerdown_n,
   input wire logic [18:0] flash_addr,
   input wire logic [7:0]  flash_dq_o,
   input wire logic        flash_dq_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   a_rp_held_low: assert property (
      $rose(aresetn) |-> !reset_powerdown_n[*3])
      else $error("reset pin released too early");
   a_ce_in_pdown: assert property (
      !reset_powerdown_n |-> flash_ce_n && flash_we_n)
      else $error("strobe while reset pin low");
   a_we_in_ce: assert property (
      !flash_we_n |-> !flash_ce_n && flash_dq_oe)
      else $error("write strobe without select or data");
   a_we_width: assert property (
      $fell(flash_we_n) |-> !flash_we_n[*4] ##1 flash_we_n)
      else $error("write strobe width wrong");
   a_we_stable: assert property (
      !flash_we_n && !$past(flash_we_n)
      |-> $stable(flash_dq_o) && $stable(flash_addr))
      else $error("address or data moved under strobe");
   a_no_clash: assert property (
      !flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
      else $error("read overlaps a drive");
   a_ce_rest: assert property (
      $rose(flash_we_n) |-> ##[0:1] flash_ce_n)
      else $error("select not released after write");
   a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
      else $error("write response dropped");
   a_r_hold: assert property (
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped or changed");
endmodule
`default_nettype wire

// [tb/fsc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
   parameter int WR_CYC = 20,
   parameter int ER_CYC = 600
) (
   // host pins
   input  wire logic        clk,
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic        rp_n,
   input  wire logic [18:0] addr,
   input  wire logic [7:0]  din,
   output wire logic [7:0]  dout,
   // fault control
   input  wire logic        vpp_ok,
   input  wire logic        fail,
   output logic      [7:0]  viol
);
   logic [7:0] mem [0:15];
   logic [7:0] last;
   logic [2:0] err;
   logic       we_q, ce_q, stat_m, wset, eset, ers, susp;
   int         busy;
   wire        rise = we_n && !we_q && !ce_q;
   wire  [7:0] sr = {busy == 0 || susp, susp, err, 3'h0};
   assign dout = (!ce_n && !oe_n && rp_n) ? (stat_m ? sr : mem[addr[3:0]])
                 : ~last;
   always @(posedge clk) begin
      we_q <= we_n;
      ce_q <= ce_n;
      last <= dout;
      if (!rp_n) begin
         {stat_m, wset, eset, ers, susp, err} <= '0;
         busy <= 0;
         viol <= 8'h00;
      end else begin
         if (busy != 0 && !susp)
            busy <= busy - 1;
         if (busy == 1 && !susp) begin
            ers <= 1'b0;
            if (fail)
               err[ers ? 2 : 1] <= 1'b1;
         end
         if (rise) begin
            wset <= 1'b0;
            eset <= 1'b0;
            stat_m <= 1'b1;
            if (busy != 0 && !susp) begin
               if (din == 8'hB0 && ers)
                  susp <= 1'b1;
               else
                  viol <= viol + 8'h01;
            end else if (wset || eset) begin
               if (!vpp_ok)
                  err[0] <= 1'b1;
               else if (eset && din != 8'hD0)
                  err[2:1] <= 2'b11;
               else if (!err[0]) begin
                  busy <= wset ? WR_CYC : ER_CYC;
                  ers <= eset;
                  if (wset)
                     mem[addr[3:0]] <= din;
               end
            end else begin
               if (susp && din != 8'hFF && din != 8'hD0 && din != 8'h70)
                  viol <= viol + 8'h01;
               case (din)
                  8'hFF: stat_m <= 1'b0;
                  8'h50: err <= 3'h0;
                  8'h40, 8'h10: wset <= 1'b1;
                  8'h20: eset <= 1'b1;
                  8'hD0: susp <= 1'b0;
                  default: ;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/fsc_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fsc_host_tb_top;
   typedef struct packed {
      logic [31:0] e;
      logic [31:0] m;
      logic [1:0]  r;
   } fsc_exp_t;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0;
   logic [31:0] s_wdata = 32'h0, d, rnd = 32'h559D16E8;
   logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0;
   logic        s_arvalid = 0, s_rready = 0, vpp_ok = 1, fail = 0;
   wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   wire  [1:0]  s_bresp, s_rresp;
   wire  [31:0] s_rdata;
   wire         flash_ce_n, flash_we_n, flash_oe_n, reset_powerdown_n;
   wire         flash_dq_oe;
   wire  [18:0] flash_addr;
   wire  [7:0]  flash_dq_o, flash_dq_i, viol;
   fsc_exp_t    rq[$], x;
   logic [1:0]  bq[$];
   int          n_fail = 0, comparisons = 0, cyc = 0;
   logic [7:0]  b;
   logic [3:0]  a;
   always #12.5 aclk = ~aclk;
   fsc_host u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .reset_powerdown_n(reset_powerdown_n),
      .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));
   fsc_flash_model u_flash (.clk(aclk), .ce_n(flash_ce_n), .we_n(flash_we_n),
      .oe_n(flash_oe_n), .rp_n(reset_powerdown_n), .addr(flash_addr),
      .din(flash_dq_o), .dout(flash_dq_i), .vpp_ok(vpp_ok), .fail(fail),
      .viol(viol));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic axi_wr(input logic [3:0] ad, input logic [31:0] wd,
                         input logic [1:0] er);
      logic aw, w;
      aw = 0;
      w = 0;
      bq.push_back(er);
      s_awaddr <= ad;
      s_wdata <= wd;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw || s_awready;
         w = w || s_wready;
         if (aw) s_awvalid <= 1'b0;
         if (w) s_wvalid <= 1'b0;
      end
      while (!s_bvalid) @(posedge aclk);
      s_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [3:0] ad, input logic [31:0] e,
                         input logic [31:0] m, input logic [1:0] er);
      rq.push_back('{e, m, er});
      s_araddr <= ad;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge aclk); while (!s_arready);
      s_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_rvalid);
      d = s_rdata;
      s_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic stat(input logic [31:0] e, input logic [31:0] m);
      axi_rd(4'hC, e, m, 2'b00);
   endtask
   task automatic poll;
      do stat(32'h0, 32'h0); while (d[8] !== 1'b0);
   endtask
   task automatic op(input logic [2:0] c);
      axi_wr(4'h0, {29'h0, c}, 2'b00);
      poll();
   endtask
   // status orders are what let the host see the erase finish
   task automatic erase_wait;
      do op(3'h7); while (d[9] !== 1'b0);
   endtask
   // results are matched in arrival order
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         wrap_up();
      end
      if (s_rvalid && s_rready && rq.size() > 0) begin
         x = rq.pop_front();
         chk(s_rdata & x.m, x.e & x.m);
         chk({30'h0, s_rresp}, {30'h0, x.r});
      end
      if (s_bvalid && s_bready && bq.size() > 0)
         chk({30'h0, s_bresp}, {30'h0, bq.pop_front()});
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      poll();
      stat(32'h0, 32'h7F00);
      axi_rd(4'h2, 32'h0, 32'hFFFFFFFF, 2'b10);
      axi_wr(4'hC, 32'h0, 2'b10);
      op(3'h0);
      stat(32'h0800, 32'h0800);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         a = rnd[3:0];
         b = rnd[15:8];
         axi_wr(4'h4, {28'h0, a}, 2'b00);
         axi_wr(4'h8, {24'h0, b}, 2'b00);
         op(3'h1);
         stat(32'h0080, 32'h7F80);
         op(3'h6);
         axi_rd(4'h8, {24'h0, b}, 32'hFF, 2'b00);
      end
      axi_wr(4'h4, 32'h0001_0000, 2'b00);
      op(3'h2);
      stat(32'h0200, 32'h0F00);
      op(3'h1);
      stat(32'h0A00, 32'h0E00);
      op(3'h3);
      stat(32'h04C0, 32'h0CC0);
      op(3'h2);
      stat(32'h0C00, 32'h0C00);
      axi_wr(4'h4, {28'h0, a}, 2'b00);
      op(3'h6);
      axi_rd(4'h8, {24'h0, b}, 32'hFF, 2'b00);
      op(3'h7);
      op(3'h4);
      stat(32'h0200, 32'h0E00);
      erase_wait();
      stat(32'h0080, 32'h7080);
      vpp_ok <= 1'b0;
      op(3'h1);
      stat(32'h1008, 32'h7808);
      vpp_ok <= 1'b1;
      op(3'h2);
      stat(32'h1800, 32'h7800);
      op(3'h5);
      stat(32'h0000, 32'h7800);
      fail <= 1'b1;
      op(3'h2);
      erase_wait();
      stat(32'h4020, 32'h7838);
      op(3'h1);
      stat(32'h6030, 32'h7838);
      op(3'h5);
      fail <= 1'b0;
      stat(32'h0000, 32'h7800);
      chk({24'h0, viol}, 32'h0);
      wrap_up();
   end
endmodule
bind fsc_host fsc_host_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_bvalid(s_bvalid), .s_bready(s_bready), .s_rvalid(s_rvalid),
   .s_rready(s_rready), .s_rdata(s_rdata), .flash_ce_n(flash_ce_n),
   .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
   .reset_powerdown_n(reset_powerdown_n), .flash_addr(flash_addr),
   .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));
`default_nettype wire
